/* include/sar_pkg.sv */
// Shared constants, types and helpers of the conversion and output port
package sar_pkg;
	localparam int MCLK_MHZ = 100;
	localparam int CONV_NS = 310;
	localparam int ACQ_NS = 77;
	localparam int WAKE_NS = 200;
	localparam int RES_W = 18;
	localparam int CNT_W = 6;
	localparam int IDX_W = 5;

	function automatic int ns_floor(input int ns);
		int c;
		c = (ns * MCLK_MHZ) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int ns_ceil(input int ns);
		int c;
		c = (ns * MCLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int CONV_CYC = ns_floor(CONV_NS);
	localparam int ACQ_CYC = ns_ceil(ACQ_NS);
	localparam int WAKE_CYC = ns_ceil(WAKE_NS);

	localparam logic [1:0] MODE_W18 = 2'h0;
	localparam logic [1:0] MODE_W16 = 2'h1;
	localparam logic [1:0] MODE_W8 = 2'h2;
	localparam logic [1:0] MODE_SER = 2'h3;
	localparam logic [1:0] SEL_HI = 2'h0;
	localparam logic [1:0] SEL_MID = 2'h1;
	localparam logic [IDX_W-1:0] SER_LAST = 5'h12;

	typedef enum logic [2:0] {
		ST_ACQ = 3'h0,
		ST_IDLE = 3'h1,
		ST_CONV = 3'h2,
		ST_NAP = 3'h3,
		ST_SHUT = 3'h4
	} conv_state_t;

	typedef struct packed {
		logic [1:0] mode;
		logic lsb_fmt;
		logic input_kind;
		logic code_format;
	} pin_cfg_t;

	typedef struct packed {
		logic cs_n;
		logic rst_pin;
		logic pd;
		logic strobe_n;
		logic [1:0] sel;
	} ctl_pins_t;

	localparam pin_cfg_t CFG_RST = 5'h00;
	localparam ctl_pins_t CTL_RST = 6'h34;

	// Raw core code is two's complement; range kind and format pins decide the MSB flip
	function automatic logic [RES_W-1:0] fmt_code(input logic [RES_W-1:0] raw,
		input logic kind, input logic fmt);
		return raw ^ {(kind ^ fmt), 17'h00000};
	endfunction
endpackage

/* logic/ser_shifter.sv */
// Serial shift-out and chain capture, running on the host's shift clock
`timescale 1ns/100ps
`default_nettype none
module ser_shifter (
	input wire logic shift_clk,
	input wire logic clear,
	input wire logic chain_in,
	input wire logic [17:0] result,
	output logic serial_bit,
	output logic started
);
	logic fell_q;
	logic [17:0] chain_q;
	logic [sar_pkg::IDX_W-1:0] idx_q;
	wire [sar_pkg::IDX_W-1:0] idx_d;
	wire own_bit;
	wire next_bit;

	// Clear comes from a busy-time flop; the shift clock is still while it drops
	assign idx_d = (idx_q == sar_pkg::SER_LAST) ? idx_q : idx_q + 5'h01;
	assign own_bit = result[5'h11 - idx_d];
	assign next_bit = (idx_d == sar_pkg::SER_LAST) ? chain_q[17] : own_bit;

	always_ff @(negedge shift_clk or posedge clear)
	begin
		if (clear)
		begin
			fell_q <= 1'b0;
			chain_q <= 18'h00000;
		end
		else
		begin
			fell_q <= 1'b1;
			chain_q <= {chain_q[16:0], chain_in};
		end
	end

	// No advance before the first falling edge keeps the MSB up
	always_ff @(posedge shift_clk or posedge clear)
	begin
		if (clear)
		begin
			idx_q <= '0;
			serial_bit <= 1'b0;
			started <= 1'b0;
		end
		else if (fell_q)
		begin
			idx_q <= idx_d;
			serial_bit <= next_bit;
			started <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* logic/sar_conversion_output_port.sv */
// Conversion control, power states and result output bus of the converter
// Notes on behaviour
// - Strobe still low when a conversion ends puts the device into nap.
// - Power-down high shuts the converter down and ignores conversion requests; the bus still follows chip select.
// - Power-down during conversion: finish first; host reads after release.
// - Strobe falling edge starts a conversion; no restart while one runs.
// - Busy is high exactly while a conversion runs.
// - Conversion takes at most 310 ns; acquisition at least 77 ns.
// - Mode 00 drives the whole 18-bit result on the bus.
// - Chip select low drives the bus; high floats every bus pin.
// - Mode 01 gives two 16-bit words on the upper pins, selected by A.
// - Mode 10 gives three bytes on the upper pins, selected by A.
// - Mode 11 shifts the result out serially on the host's shift clock.
// - Serial data changes after rising edges; MSB held past first fall.
// - Chain input is captured on falling edges, emerging 18 cycles later.
// - Range kind and code format pins set the code in every mode.
// - Reset pin high floats the bus, halts conversion, ignores requests.
`timescale 1ns/100ps
`default_nettype none
module sar_conversion_output_port (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic shift_clk,
	input wire logic conv_start_strobe_n,
	input wire logic power_down_pin,
	input wire logic reset_pin,
	input wire logic chip_select_n,
	input wire logic [1:0] mode_pins,
	input wire logic lsb_format_pin,
	input wire logic input_kind_select,
	input wire logic code_format_select,
	input wire logic [1:0] word_select_in,
	input wire logic [17:0] sample_code,
	input wire logic chain_in,
	output logic [17:0] data_out,
	output logic [17:0] data_oe_n,
	output logic serial_out,
	output logic serial_oe_n,
	output logic busy,
	output logic nap,
	output logic shutdown
);
	localparam int CONV_BOUND = sar_pkg::CONV_CYC;
	localparam logic [sar_pkg::CNT_W-1:0] CONV_END = 6'(sar_pkg::CONV_CYC - 1);
	localparam logic [sar_pkg::CNT_W-1:0] ACQ_END = 6'(sar_pkg::ACQ_CYC - 1);
	localparam logic [sar_pkg::CNT_W-1:0] WAKE_MIN = 6'(sar_pkg::WAKE_CYC);

	sar_pkg::ctl_pins_t ctl_m_q;
	sar_pkg::ctl_pins_t ctl_q;
	sar_pkg::pin_cfg_t cfg_m_q;
	sar_pkg::pin_cfg_t cfg_q;
	logic strb_prev_q;
	sar_pkg::conv_state_t state_q;
	sar_pkg::conv_state_t state_d;
	logic [sar_pkg::CNT_W-1:0] cnt_q;
	logic [sar_pkg::CNT_W-1:0] cnt_d;
	logic [17:0] res_q;
	logic clear_q;
	logic ser_bit;
	logic ser_started;

	wire sar_pkg::ctl_pins_t ctl_raw;
	wire sar_pkg::pin_cfg_t cfg_raw;
	wire fall;
	wire rp;
	wire pd;
	wire conv_done;
	wire acq_done;
	wire wake_ok;
	wire drive;
	wire [17:0] lo16;
	wire [17:0] lo8;
	wire [17:0] w16;
	wire [17:0] w8;
	wire [17:0] bus_d;
	wire [17:0] mask;
	wire [17:0] oe_n_d;
	wire [17:0] res_fmt;

	function automatic logic [17:0] mode_mask(input logic [1:0] m);
		logic [17:0] v;
		v = 18'h00000;
		unique case (m)
			sar_pkg::MODE_W18: v = 18'h3ffff;
			sar_pkg::MODE_W16: v = 18'h3fffc;
			sar_pkg::MODE_W8: v = 18'h3fc00;
			sar_pkg::MODE_SER: v = 18'h00000;
		endcase
		return v;
	endfunction

	assign ctl_raw = {chip_select_n, reset_pin, power_down_pin, conv_start_strobe_n,
		word_select_in};
	assign cfg_raw = {mode_pins, lsb_format_pin, input_kind_select, code_format_select};

	// Pins are asynchronous to mclk; only the second stage is looked at
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ctl_m_q <= sar_pkg::CTL_RST;
			ctl_q <= sar_pkg::CTL_RST;
			cfg_m_q <= sar_pkg::CFG_RST;
			cfg_q <= sar_pkg::CFG_RST;
			strb_prev_q <= 1'b1;
		end
		else
		begin
			ctl_m_q <= ctl_raw;
			ctl_q <= ctl_m_q;
			cfg_m_q <= cfg_raw;
			cfg_q <= cfg_m_q;
			strb_prev_q <= ctl_q.strobe_n;
		end
	end

	assign fall = strb_prev_q & ~ctl_q.strobe_n;
	assign rp = ctl_q.rst_pin;
	assign pd = ctl_q.pd;
	assign conv_done = (state_q == sar_pkg::ST_CONV) && (cnt_q == CONV_END);
	assign acq_done = (cnt_q == ACQ_END);
	assign wake_ok = (cnt_q >= WAKE_MIN);

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q + 6'h01;
		if (rp)
		begin
			state_d = sar_pkg::ST_ACQ;
			cnt_d = '0;
		end
		else
		begin
			unique case (state_q)
				sar_pkg::ST_ACQ:
				begin
					if (pd)
					begin
						state_d = sar_pkg::ST_SHUT;
						cnt_d = '0;
					end
					else if (acq_done)
					begin
						state_d = sar_pkg::ST_IDLE;
						cnt_d = '0;
					end
				end
				sar_pkg::ST_IDLE:
				begin
					cnt_d = '0;
					if (pd)
						state_d = sar_pkg::ST_SHUT;
					else if (fall)
						state_d = sar_pkg::ST_CONV;
				end
				sar_pkg::ST_CONV:
				begin
					// Strobe edges are ignored until the count ends
					if (conv_done)
					begin
						cnt_d = '0;
						if (pd)
							state_d = sar_pkg::ST_SHUT;
						else if (!ctl_q.strobe_n)
							state_d = sar_pkg::ST_NAP;
						else
							state_d = sar_pkg::ST_ACQ;
					end
				end
				sar_pkg::ST_NAP:
				begin
					// Counts strobe-high time; a short pulse leaves the device napping
					if (pd)
					begin
						state_d = sar_pkg::ST_SHUT;
						cnt_d = '0;
					end
					else if (ctl_q.strobe_n)
						cnt_d = wake_ok ? cnt_q : cnt_q + 6'h01;
					else
					begin
						cnt_d = '0;
						if (fall && wake_ok)
							state_d = sar_pkg::ST_CONV;
					end
				end
				sar_pkg::ST_SHUT:
				begin
					cnt_d = '0;
					if (!pd)
						state_d = sar_pkg::ST_ACQ;
				end
				default:
				begin
					state_d = sar_pkg::ST_ACQ;
					cnt_d = '0;
				end
			endcase
		end
	end

	// Format is taken at capture, so a result never changes under a reader
	assign res_fmt = sar_pkg::fmt_code(sample_code, cfg_q.input_kind, cfg_q.code_format);

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_q <= sar_pkg::ST_ACQ;
			cnt_q <= '0;
			res_q <= 18'h00000;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			if (conv_done && !rp)
				res_q <= res_fmt;
		end
	end

	assign drive = !ctl_q.cs_n && !rp;
	assign lo16 = cfg_q.lsb_fmt ? {14'h0000, res_q[1:0], 2'h0} : {res_q[1:0], 16'h0000};
	assign lo8 = cfg_q.lsb_fmt ? {6'h00, res_q[1:0], 10'h000} : {res_q[1:0], 16'h0000};
	assign w16 = (ctl_q.sel == sar_pkg::SEL_HI) ? {res_q[17:2], 2'h0} : lo16;
	assign w8 = (ctl_q.sel == sar_pkg::SEL_HI) ? {res_q[17:10], 10'h000} :
		(ctl_q.sel == sar_pkg::SEL_MID) ? {res_q[9:2], 10'h000} : lo8;
	assign bus_d = (cfg_q.mode == sar_pkg::MODE_W18) ? res_q :
		(cfg_q.mode == sar_pkg::MODE_W16) ? w16 :
		(cfg_q.mode == sar_pkg::MODE_W8) ? w8 : 18'h00000;
	assign mask = mode_mask(cfg_q.mode);
	assign oe_n_d = drive ? ~mask : 18'h3ffff;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			data_out <= 18'h00000;
			data_oe_n <= 18'h3ffff;
			serial_oe_n <= 1'b1;
			busy <= 1'b0;
			nap <= 1'b0;
			shutdown <= 1'b0;
			clear_q <= 1'b1;
		end
		else
		begin
			data_out <= bus_d & mask;
			data_oe_n <= oe_n_d;
			serial_oe_n <= !(drive && cfg_q.mode == sar_pkg::MODE_SER);
			busy <= (state_d == sar_pkg::ST_CONV);
			nap <= (state_d == sar_pkg::ST_NAP);
			shutdown <= (state_d == sar_pkg::ST_SHUT);
			clear_q <= (state_d == sar_pkg::ST_CONV) | conv_done | rp;
		end
	end

	ser_shifter u_shift (
		.shift_clk(shift_clk),
		.clear(clear_q),
		.chain_in(chain_in),
		.result(res_q),
		.serial_bit(ser_bit),
		.started(ser_started)
	);

	// Before the first shift the MSB comes straight from the result register
	assign serial_out = ser_started ? ser_bit : res_q[17];

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence conv_run;
		busy [*8];
	endsequence

	sequence conv_end;
		##[1:CONV_BOUND] !busy;
	endsequence

	a_nap_entry: assert property (conv_done && !ctl_q.strobe_n && !pd && !rp |=> nap)
		else $error("no nap after conversion with strobe low");
	a_shut_ignore: assert property (shutdown && fall && pd && !rp |=> !busy)
		else $error("conversion started during power shutdown");
	a_pd_finish: assert property (busy && pd && !rp && !conv_done |=> busy)
		else $error("conversion cut short by power down");
	a_start_fall: assert property (state_q == sar_pkg::ST_IDLE && fall && !pd && !rp |=> busy)
		else $error("falling strobe did not start conversion");
	a_busy_len: assert property ($rose(busy) |-> conv_run ##0 conv_end)
		else $error("busy length out of bounds");
	a_busy_state: assert property (busy == (state_q == sar_pkg::ST_CONV))
		else $error("busy disagrees with conversion state");
	a_reset_hiz: assert property (rp |=> (&data_oe_n) && !busy && serial_oe_n)
		else $error("bus driven or busy during reset pin");
	a_cs_hiz: assert property (ctl_q.cs_n |=> &data_oe_n)
		else $error("bus driven with chip select high");
	a_word18: assert property (drive && cfg_q.mode == sar_pkg::MODE_W18 |=>
		data_out == $past(res_q) && data_oe_n == 18'h00000)
		else $error("full word not on bus");
	a_sel16: assert property (drive && cfg_q.mode == sar_pkg::MODE_W16 &&
		ctl_q.sel == sar_pkg::SEL_HI |=> data_out[17:2] == $past(res_q[17:2]))
		else $error("upper 16-bit word wrong");
	a_acq_wait: assert property ($fell(rp) |-> !busy [*8])
		else $error("conversion before acquisition time after reset");
endmodule
`default_nettype wire

/* test/host_model.sv */
// Host side model: shift clock source, chain feeder and serial reader
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input wire logic go,
	input wire logic busy,
	input wire logic serial_out,
	input wire logic [3:0] chain_pat,
	output logic shift_clk,
	output logic chain_in,
	output logic [21:0] word,
	output logic done
);
	initial
	begin
		shift_clk = 1'b0;
		chain_in = 1'b0;
		word = '0;
		done = 1'b0;
		forever
		begin
			// Clock stays still while a conversion runs
			wait (go && !busy);
			done = 1'b0;
			#3.3;
			// Whole result plus four chained bits before the frame ends
			for (int i = 0; i < 22; i++)
			begin
				shift_clk = 1'b1;
				chain_in = (i < 4) ? chain_pat[3-i] : ~chain_in;
				#7.5;
				word = {word[20:0], serial_out};
				shift_clk = 1'b0;
				#7.5;
			end
			chain_in = ~chain_in;
			done = 1'b1;
			wait (!go);
			// A stale done would let the next request end before its frame
			done = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* test/test_sar_conversion_output_port.sv */
// Self-checking bench for the conversion and output port
`timescale 1ns/100ps
`default_nettype none
module test_sar_conversion_output_port;
	logic mclk, rst_n, strobe_n, pd, rpin, cs_n, lsb, kind, cf, go, snap_q, busy_p;
	logic [1:0] mode, sel;
	logic [17:0] code, res, d, oe;
	logic [3:0] pat;
	logic shift_clk, chain_in, ser, ser_oe_n, busy, nap, shut, done;
	logic [21:0] word;
	logic [39:0] exp_q[$];
	int num_errors = 0, cmp_count = 0, bcnt = 0, cyc = 0;
	logic e_nap = 1'b0, e_shut = 1'b0;

	sar_conversion_output_port dut (
		.mclk(mclk), .rst_n(rst_n), .shift_clk(shift_clk), .conv_start_strobe_n(strobe_n),
		.power_down_pin(pd), .reset_pin(rpin), .chip_select_n(cs_n), .mode_pins(mode),
		.lsb_format_pin(lsb), .input_kind_select(kind), .code_format_select(cf),
		.word_select_in(sel), .sample_code(code), .chain_in(chain_in), .data_out(d),
		.data_oe_n(oe), .serial_out(ser), .serial_oe_n(ser_oe_n), .busy(busy), .nap(nap),
		.shutdown(shut)
	);
	host_model hm (
		.go(go), .busy(busy), .serial_out(ser), .chain_pat(pat), .shift_clk(shift_clk),
		.chain_in(chain_in), .word(word), .done(done)
	);

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge mclk)
	begin
		busy_p <= busy;
		bcnt <= busy ? bcnt + 1 : 0;
		if (busy_p === 1'b1 && busy === 1'b0 && !rpin)
			check(40'(bcnt), exp_q.pop_front());
		if (snap_q)
			check({busy, nap, shut, ser_oe_n, oe, d & ~oe}, exp_q.pop_front());
		cyc++;
		if (cyc == 3000)
		begin
			num_errors++;
			summarize();
		end
	end

	always @(posedge done)
		check(40'(word), exp_q.pop_front());

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	function automatic logic [39:0] state_v(input logic [1:0] m, input logic [1:0] a, input logic f);
		logic [17:0] dd, oo;
		dd = res;
		oo = 18'h0;
		if (m == 2'h1)
		begin
			oo = 18'h3;
			dd = (a == 2'h0) ? {res[17:2], 2'h0} : f ? {14'h0, res[1:0], 2'h0} : {res[1:0], 16'h0};
		end
		if (m == 2'h2)
		begin
			oo = 18'h3ff;
			dd = (a == 2'h0) ? {res[17:10], 10'h0} : (a == 2'h1) ? {res[9:2], 10'h0}
				: f ? {6'h0, res[1:0], 10'h0} : {res[1:0], 16'h0};
		end
		if (m == 2'h3 || cs_n || rpin)
			oo = 18'h3ffff;
		return {1'b0, e_nap, e_shut, !(m == 2'h3 && !cs_n), oo, dd & ~oo};
	endfunction

	task automatic rd(input logic [1:0] m, input logic [1:0] a, input logic f);
		mode <= m;
		sel <= a;
		lsb <= f;
		tick(5);
		exp_q.push_back(state_v(m, a, f));
		snap_q <= 1'b1;
		tick(1);
		snap_q <= 1'b0;
	endtask

	task automatic conv(input int hi, input logic stay, input logic pdn);
		strobe_n <= 1'b1;
		code <= 18'($urandom);
		kind <= 1'($urandom);
		cf <= 1'($urandom);
		tick(hi);
		res = code ^ {kind ^ cf, 17'h0};
		exp_q.push_back(40'h1f);
		strobe_n <= 1'b0;
		tick(2);
		strobe_n <= !stay;
		tick(4);
		pd <= pdn;
		tick(34);
		e_nap = stay;
	endtask

	initial
	begin
		{rst_n, pd, rpin, cs_n, lsb, kind, cf, go, snap_q} = '0;
		strobe_n = 1'b1;
		mode = 2'h0;
		sel = 2'h0;
		code = 18'h0;
		res = 18'h0;
		pat = 4'h9;
		void'($urandom(32'hca15));
		tick(3);
		rst_n <= 1'b1;
		tick(16);
		repeat (3)
		begin
			conv(12, 1'b0, 1'b0);
			for (int m = 0; m < 3; m++)
				for (int a = 0; a < 4; a++)
				begin
					rd(2'(m), 2'(a), 1'b0);
					rd(2'(m), 2'(a), 1'b1);
				end
			cs_n <= 1'b1;
			rd(2'h1, 2'($urandom), 1'b0);
			cs_n <= 1'b0;
			rd(2'h3, 2'h0, 1'b0);
			exp_q.push_back({18'h0, res, pat});
			go <= 1'b1;
			while (done !== 1'b1)
				tick(1);
			go <= 1'b0;
			pat <= 4'($urandom);
		end
		conv(12, 1'b1, 1'b0);
		rd(2'h0, 2'h0, 1'b0);
		strobe_n <= 1'b1;
		tick(5);
		strobe_n <= 1'b0;
		rd(2'h0, 2'h0, 1'b0);
		conv(25, 1'b0, 1'b0);
		cs_n <= 1'b1;
		conv(12, 1'b0, 1'b1);
		e_shut = 1'b1;
		rd(2'h0, 2'h0, 1'b0);
		strobe_n <= 1'b0;
		tick(3);
		strobe_n <= 1'b1;
		rd(2'h0, 2'h0, 1'b0);
		pd <= 1'b0;
		cs_n <= 1'b0;
		e_shut = 1'b0;
		// Recovery cut short: there is no reference to settle here
		tick(20);
		rd(2'h0, 2'h0, 1'b0);
		strobe_n <= 1'b0;
		tick(2);
		strobe_n <= 1'b1;
		tick(8);
		rpin <= 1'b1;
		rd(2'h0, 2'h0, 1'b0);
		strobe_n <= 1'b0;
		tick(2);
		strobe_n <= 1'b1;
		rd(2'h0, 2'h0, 1'b0);
		rpin <= 1'b0;
		tick(1);
		strobe_n <= 1'b0;
		tick(2);
		strobe_n <= 1'b1;
		rd(2'h0, 2'h0, 1'b0);
		conv(12, 1'b0, 1'b0);
		rd(2'h0, 2'h0, 1'b0);
		tick(5);
		check(40'(exp_q.size()), 40'h0);
		summarize();
	end
endmodule
`default_nettype wire
